// ### src/trc_top.sv
// Timer core: counter, prescaler, modulus and byte register access.
// Assumes one read or write strobe per cycle from a same-clock host and debug controller.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_top #(
    parameter int N_CH = 2
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Byte register access
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [`TRC_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Debug state
    input wire logic i_debug_active,
    // Timer state
    output logic [15:0] o_counter_value,
    output logic [15:0] o_modulus_value,
    output logic [16*N_CH-1:0] o_channel_value
);
    trc_pkg::trc_byte_t sc_reg, sc_next;
    trc_pkg::trc_word_t cnt_reg, cnt_next;
    logic [`TRC_DIV_W-1:0] div_reg, div_next;
    logic down_reg, down_next;
    trc_pkg::trc_word_t mod_reg, mod_next;
    trc_pkg::trc_word_t mbuf_reg, mbuf_next;
    logic [1:0] mpend_reg, mpend_next;
    logic rlat_reg, rlat_next;
    logic rwait_hi_reg, rwait_hi_next;
    trc_pkg::trc_word_t rbuf_reg, rbuf_next;
    trc_pkg::trc_byte_t rdata_reg, rdata_next;
    logic clocks_on, tick, pwm_update, cnt_wr;
    logic [`TRC_DIV_W-1:0] div_limit;
    trc_pkg::trc_word_t top;
    trc_pkg::trc_byte_t chan_rdata [N_CH];
    logic [N_CH-1:0] chan_hit;

    // ------------------------------------------------------------------
    // Count timing
    // ------------------------------------------------------------------
    always_comb begin
        clocks_on = sc_reg[`TRC_SC_CLKS_HI:`TRC_SC_CLKS_LO] != `TRC_CLKS_OFF;
        div_limit = `TRC_DIV_W'((1 << sc_reg[`TRC_SC_PS_HI:`TRC_SC_PS_LO]) - 1);
        top = (mod_reg == `TRC_RST_WORD) ? `TRC_FULL_COUNT : mod_reg;
        // The counter stops counting while the debug controller has the core halted; a counter write still clears it.
        tick = clocks_on && !i_debug_active && (div_reg == div_limit);
        pwm_update = tick && !down_reg && (cnt_reg == top - 16'h0001);
        cnt_wr = i_wr_en && (i_addr == `TRC_OFS_CNTH || i_addr == `TRC_OFS_CNTL);
    end

    // ------------------------------------------------------------------
    // Core register next values
    // ------------------------------------------------------------------
    always_comb begin
        sc_next = sc_reg;
        cnt_next = cnt_reg;
        div_next = div_reg;
        down_next = down_reg;
        mod_next = mod_reg;
        mbuf_next = mbuf_reg;
        mpend_next = mpend_reg;
        rlat_next = rlat_reg;
        rwait_hi_next = rwait_hi_reg;
        rbuf_next = rbuf_reg;
        if (clocks_on && !i_debug_active) begin
            div_next = (div_reg == div_limit) ? '0 : div_reg + 1'b1;
        end
        if (tick) begin
            if (!sc_reg[`TRC_SC_CPWM]) begin
                cnt_next = (cnt_reg >= top) ? `TRC_RST_WORD : cnt_reg + 16'h0001;
                down_next = 1'b0;
            end else if (!down_reg) begin
                down_next = cnt_reg >= top;
                cnt_next = (cnt_reg >= top) ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
            end else begin
                down_next = cnt_reg != `TRC_RST_WORD;
                cnt_next = (cnt_reg == `TRC_RST_WORD) ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
            end
        end
        if (cnt_wr) begin
            cnt_next = `TRC_RST_WORD;
            div_next = '0;
            down_next = 1'b0;
        end
        if (i_wr_en && i_addr == `TRC_OFS_SC) begin
            sc_next = i_wdata;
            if (i_debug_active) begin
                mpend_next = 2'h0;
            end
        end
        if (i_debug_active && (cnt_wr || (i_wr_en && i_addr == `TRC_OFS_SC))) begin
            rlat_next = 1'b0;
        end
        // The modulus takes effect only once both bytes have arrived.
        if (i_wr_en && i_addr == `TRC_OFS_MODH) begin
            mbuf_next[15:8] = i_wdata;
            mpend_next[1] = 1'b1;
        end
        if (i_wr_en && i_addr == `TRC_OFS_MODL) begin
            mbuf_next[7:0] = i_wdata;
            mpend_next[0] = 1'b1;
        end
        if (mpend_reg == 2'h3) begin
            mod_next = mbuf_reg;
            mpend_next = 2'h0;
        end
        if (!i_debug_active && i_rd_en &&
            (i_addr == `TRC_OFS_CNTH || i_addr == `TRC_OFS_CNTL)) begin
            if (!rlat_reg) begin
                rlat_next = 1'b1;
                rbuf_next = cnt_reg;
                rwait_hi_next = i_addr == `TRC_OFS_CNTL;
            end else if (rwait_hi_reg == (i_addr == `TRC_OFS_CNTH)) begin
                rlat_next = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = rdata_reg;
        if (i_rd_en) begin
            rdata_next = `TRC_RST_BYTE;
            unique case (i_addr)
                `TRC_OFS_SC: rdata_next = sc_reg;
                `TRC_OFS_CNTH: rdata_next = (rlat_reg && !i_debug_active) ?
                    rbuf_reg[15:8] : cnt_reg[15:8];
                `TRC_OFS_CNTL: rdata_next = (rlat_reg && !i_debug_active) ?
                    rbuf_reg[7:0] : cnt_reg[7:0];
                `TRC_OFS_MODH: rdata_next = mod_reg[15:8];
                `TRC_OFS_MODL: rdata_next = mod_reg[7:0];
                default: begin
                    for (int i = 0; i < N_CH; i++) begin
                        if (chan_hit[i]) begin
                            rdata_next = chan_rdata[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sc_reg <= `TRC_RST_BYTE;
            cnt_reg <= `TRC_RST_WORD;
            div_reg <= '0;
            down_reg <= 1'b0;
            mod_reg <= `TRC_RST_WORD;
            mbuf_reg <= `TRC_RST_WORD;
            mpend_reg <= 2'h0;
            rlat_reg <= 1'b0;
            rwait_hi_reg <= 1'b0;
            rbuf_reg <= `TRC_RST_WORD;
            rdata_reg <= `TRC_RST_BYTE;
        end else begin
            sc_reg <= sc_next;
            cnt_reg <= cnt_next;
            div_reg <= div_next;
            down_reg <= down_next;
            mod_reg <= mod_next;
            mbuf_reg <= mbuf_next;
            mpend_reg <= mpend_next;
            rlat_reg <= rlat_next;
            rwait_hi_reg <= rwait_hi_next;
            rbuf_reg <= rbuf_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        localparam logic [`TRC_ADDR_W-1:0] BASE =
            `TRC_ADDR_W'(`TRC_OFS_CH_BASE + g * `TRC_CH_STRIDE);
        trc_chan_if u_if();
        assign u_if.wr_sc = i_wr_en && i_addr == BASE + `TRC_CH_OFS_SC;
        assign u_if.wr_vh = i_wr_en && i_addr == BASE + `TRC_CH_OFS_VH;
        assign u_if.wr_vl = i_wr_en && i_addr == BASE + `TRC_CH_OFS_VL;
        assign u_if.rd_vh = i_rd_en && i_addr == BASE + `TRC_CH_OFS_VH;
        assign u_if.rd_vl = i_rd_en && i_addr == BASE + `TRC_CH_OFS_VL;
        assign u_if.wdata = i_wdata;
        assign u_if.debug = i_debug_active;
        assign u_if.clocks_on = clocks_on;
        assign u_if.cpwm = sc_reg[`TRC_SC_CPWM];
        assign u_if.tick = tick;
        assign u_if.pwm_update = pwm_update;
        assign chan_hit[g] = i_addr >= BASE && i_addr <= BASE + `TRC_CH_OFS_VL &&
            i_addr != BASE + `TRC_CH_OFS_SC || i_addr == BASE;
        assign chan_rdata[g] = (i_addr == BASE) ? u_if.sc : u_if.rdata;
        assign o_channel_value[16*g +: 16] = u_if.value;
        trc_channel u_chan (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .ch(u_if.chan)
        );
    end

    assign o_rdata = rdata_reg;
    assign o_counter_value = cnt_reg;
    assign o_modulus_value = mod_reg;
endmodule

// ### src/trc_map.svh
// Register offsets, field positions, reset values and limits of the timer block.
// Assumes inclusion by bare name from every file of the block.
`ifndef TRC_MAP_SVH
`define TRC_MAP_SVH

// ----------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------
`define TRC_ADDR_W 4
`define TRC_OFS_SC 4'h0
`define TRC_OFS_CNTH 4'h1
`define TRC_OFS_CNTL 4'h2
`define TRC_OFS_MODH 4'h3
`define TRC_OFS_MODL 4'h4
`define TRC_OFS_CH_BASE 4'h5
`define TRC_CH_STRIDE 4'h3
`define TRC_CH_OFS_SC 4'h0
`define TRC_CH_OFS_VH 4'h1
`define TRC_CH_OFS_VL 4'h2

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define TRC_SC_CPWM 5
`define TRC_SC_CLKS_HI 4
`define TRC_SC_CLKS_LO 3
`define TRC_SC_PS_HI 2
`define TRC_SC_PS_LO 0
`define TRC_CLKS_OFF 2'h0
`define TRC_CSC_MS_HI 5
`define TRC_CSC_MS_LO 4
`define TRC_MS_CAPTURE 2'h0
`define TRC_MS_COMPARE 2'h1

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define TRC_RST_BYTE 8'h00
`define TRC_RST_WORD 16'h0000
`define TRC_FULL_COUNT 16'hffff
`define TRC_DIV_W 7

`endif

// ### src/trc_pkg.sv
// Types shared by the timer block modules.
// Assumes trc_map.svh is on the include path.
package trc_pkg;

    typedef logic [7:0] trc_byte_t;
    typedef logic [15:0] trc_word_t;

    typedef enum logic [1:0] {
        TRC_MODE_CAPTURE,
        TRC_MODE_COMPARE,
        TRC_MODE_EDGE_PWM,
        TRC_MODE_CENTER_PWM
    } trc_mode_t;

endpackage

// ### src/trc_chan_if.sv
// Link between the timer core and one channel value unit.
// Assumes strobes are single-cycle pulses on the core clock.
`timescale 1ns/1ps
interface trc_chan_if;
    logic wr_sc;
    logic wr_vh;
    logic wr_vl;
    logic rd_vh;
    logic rd_vl;
    trc_pkg::trc_byte_t wdata;
    logic debug;
    logic clocks_on;
    logic cpwm;
    logic tick;
    logic pwm_update;
    trc_pkg::trc_byte_t rdata;
    trc_pkg::trc_byte_t sc;
    trc_pkg::trc_word_t value;

    modport core (
        output wr_sc, wr_vh, wr_vl, rd_vh, rd_vl, wdata, debug, clocks_on, cpwm, tick,
        output pwm_update,
        input rdata, sc, value
    );
    modport chan (
        input wr_sc, wr_vh, wr_vl, rd_vh, rd_vl, wdata, debug, clocks_on, cpwm, tick,
        input pwm_update,
        output rdata, sc, value
    );
endinterface

// ### src/trc_channel.sv
// One channel: status/control byte, buffered value and read latch.
// Assumes the core supplies count ticks and the PWM update event.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_channel (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Core link
    trc_chan_if.chan ch
);
    trc_pkg::trc_byte_t sc_reg, sc_next;
    trc_pkg::trc_word_t val_reg, val_next;
    trc_pkg::trc_word_t wbuf_reg, wbuf_next;
    logic [1:0] wpend_reg, wpend_next;
    logic rlat_reg, rlat_next;
    logic rwait_hi_reg, rwait_hi_next;
    trc_pkg::trc_word_t rbuf_reg, rbuf_next;
    trc_pkg::trc_mode_t mode;
    logic commit;

    // ------------------------------------------------------------------
    // Mode and commit timing
    // ------------------------------------------------------------------
    always_comb begin
        if (ch.cpwm) begin
            mode = trc_pkg::TRC_MODE_CENTER_PWM;
        end else if (sc_reg[`TRC_CSC_MS_HI:`TRC_CSC_MS_LO] == `TRC_MS_CAPTURE) begin
            mode = trc_pkg::TRC_MODE_CAPTURE;
        end else if (sc_reg[`TRC_CSC_MS_HI:`TRC_CSC_MS_LO] == `TRC_MS_COMPARE) begin
            mode = trc_pkg::TRC_MODE_COMPARE;
        end else begin
            mode = trc_pkg::TRC_MODE_EDGE_PWM;
        end
        commit = 1'b0;
        if (wpend_reg == 2'h3) begin
            if (!ch.clocks_on) begin
                commit = 1'b1;
            end else if (mode == trc_pkg::TRC_MODE_COMPARE) begin
                commit = ch.tick;
            end else if (mode != trc_pkg::TRC_MODE_CAPTURE) begin
                commit = ch.pwm_update;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------
    always_comb begin
        sc_next = sc_reg;
        val_next = val_reg;
        wbuf_next = wbuf_reg;
        wpend_next = wpend_reg;
        rlat_next = rlat_reg;
        rwait_hi_next = rwait_hi_reg;
        rbuf_next = rbuf_reg;
        if (commit) begin
            val_next = wbuf_reg;
            wpend_next = 2'h0;
        end
        if (ch.wr_sc) begin
            sc_next = ch.wdata;
            if (ch.debug) begin
                rlat_next = 1'b0;
            end
        end
        // Capture mode owns the value, so a write there is dropped.
        if (mode != trc_pkg::TRC_MODE_CAPTURE) begin
            if (ch.wr_vh) begin
                wbuf_next[15:8] = ch.wdata;
                wpend_next[1] = 1'b1;
            end
            if (ch.wr_vl) begin
                wbuf_next[7:0] = ch.wdata;
                wpend_next[0] = 1'b1;
            end
        end
        if (!ch.debug && (ch.rd_vh || ch.rd_vl)) begin
            if (!rlat_reg) begin
                rlat_next = 1'b1;
                rbuf_next = val_reg;
                rwait_hi_next = ch.rd_vl;
            end else if (rwait_hi_reg == ch.rd_vh) begin
                rlat_next = 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sc_reg <= `TRC_RST_BYTE;
            val_reg <= `TRC_RST_WORD;
            wbuf_reg <= `TRC_RST_WORD;
            wpend_reg <= 2'h0;
            rlat_reg <= 1'b0;
            rwait_hi_reg <= 1'b0;
            rbuf_reg <= `TRC_RST_WORD;
        end else begin
            sc_reg <= sc_next;
            val_reg <= val_next;
            wbuf_reg <= wbuf_next;
            wpend_reg <= wpend_next;
            rlat_reg <= rlat_next;
            rwait_hi_reg <= rwait_hi_next;
            rbuf_reg <= rbuf_next;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        if (ch.rd_vh) begin
            ch.rdata = (rlat_reg && !ch.debug) ? rbuf_reg[15:8] : val_reg[15:8];
        end else begin
            ch.rdata = (rlat_reg && !ch.debug) ? rbuf_reg[7:0] : val_reg[7:0];
        end
    end

    assign ch.sc = sc_reg;
    assign ch.value = val_reg;
endmodule

// ### verification/trc_checker_assertions.sv
// Port checks for the timer block, attached to its top module by bind.
// Assumes the byte map of trc_map.svh and a single clock domain.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_checker #(
    parameter int N_CH = 2
) (
    // Watched ports
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [`TRC_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic i_debug_active,
    input wire logic [15:0] o_counter_value,
    input wire logic [15:0] o_modulus_value,
    input wire logic [16*N_CH-1:0] o_channel_value
);
    // ----------------
    // Control shadow
    // ----------------
    // Mode bits are tracked from writes so commit timing can be judged.
    logic [7:0] sc_reg;
    logic [7:0] sc_next;
    logic [7:0] cs0_reg;
    logic [7:0] cs0_next;
    logic [7:0] cs1_reg;
    logic [7:0] cs1_next;
    always_comb begin
        sc_next = sc_reg;
        cs0_next = cs0_reg;
        cs1_next = cs1_reg;
        if (i_wr_en && i_addr == `TRC_OFS_SC)
            sc_next = i_wdata;
        if (i_wr_en && i_addr == `TRC_OFS_CH_BASE)
            cs0_next = i_wdata;
        if (i_wr_en && i_addr == `TRC_OFS_CH_BASE + `TRC_CH_STRIDE)
            cs1_next = i_wdata;
    end
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sc_reg <= 8'h00;
            cs0_reg <= 8'h00;
            cs1_reg <= 8'h00;
        end else begin
            sc_reg <= sc_next;
            cs0_reg <= cs0_next;
            cs1_reg <= cs1_next;
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_cnt_write_clear: assert property (
        i_wr_en && (i_addr == `TRC_OFS_CNTH || i_addr == `TRC_OFS_CNTL)
        |=> o_counter_value == 16'h0000) else $error("counter not cleared by write");
    a_debug_frozen: assert property (
        $past(i_debug_active) && !$past(i_wr_en) |-> $stable(o_counter_value))
        else $error("counter moved in debug");
    a_debug_cnt_read: assert property (
        i_rd_en && i_debug_active && i_addr == `TRC_OFS_CNTL
        |=> o_rdata == $past(o_counter_value[7:0])) else $error("debug counter read stale");
    a_debug_val_read: assert property (
        i_rd_en && i_debug_active && i_addr == 4'h7
        |=> o_rdata == $past(o_channel_value[7:0])) else $error("debug value read stale");
    a_capture_no_write: assert property (
        $past(cs1_reg[5:4]) == 2'h0 && !$past(sc_reg[5]) |-> $stable(o_channel_value[31:16]))
        else $error("capture channel value changed");
    a_compare_at_tick: assert property (
        $changed(o_channel_value[15:0]) && $past(sc_reg[4:3]) != 2'h0 && !$past(sc_reg[5])
        && $past(cs0_reg[5:4]) == 2'h1 |-> $changed(o_counter_value))
        else $error("compare value committed off tick");
    a_pwm_at_top: assert property (
        $changed(o_channel_value[15:0]) && $past(sc_reg[4:3]) != 2'h0
        && ($past(cs0_reg[5]) || $past(sc_reg[5])) && o_modulus_value != 16'h0000
        |-> o_counter_value == o_modulus_value
        && $past(o_counter_value) == o_modulus_value - 16'h0001)
        else $error("pwm value committed off top");
    a_mod_pair_drop: assert property (
        i_wr_en && i_debug_active && i_addr == `TRC_OFS_SC ##1 i_wr_en && i_addr == `TRC_OFS_MODL
        |=> $stable(o_modulus_value) [*2]) else $error("modulus committed one byte");
    c_pwm_commit: cover property ($changed(o_channel_value[15:0]) && o_counter_value != 0);
    c_debug_read: cover property (i_rd_en && i_debug_active);
    c_debug_mod: cover property (i_wr_en && i_debug_active && i_addr == `TRC_OFS_MODL);
endmodule

bind trc_top trc_checker #(.N_CH(N_CH)) trc_checker_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_debug_active(i_debug_active),
    .o_counter_value(o_counter_value), .o_modulus_value(o_modulus_value),
    .o_channel_value(o_channel_value)
);

// ### verification/test_trc_top.sv
// Directed bench for the timer block: byte access, read latches, debug and commits.
// Assumes the checker is bound to the design and the byte map of trc_map.svh.
`timescale 1ns/1ps
`include "trc_map.svh"
module test_trc_top;
    // ----------------
    // Design and clock
    // ----------------
    localparam logic [3:0] C0_SC = `TRC_OFS_CH_BASE;
    localparam logic [3:0] C0_VH = C0_SC + `TRC_CH_OFS_VH;
    localparam logic [3:0] C0_VL = C0_SC + `TRC_CH_OFS_VL;
    localparam logic [3:0] C1_VH = C0_VH + `TRC_CH_STRIDE;
    localparam logic [3:0] C1_VL = C0_VL + `TRC_CH_STRIDE;
    logic i_ref_clk;
    logic i_sys_rst;
    logic i_wr_en;
    logic i_rd_en;
    logic i_debug_active;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic [7:0] o_rdata;
    logic [7:0] rv;
    logic [15:0] o_counter_value;
    logic [15:0] o_modulus_value;
    logic [15:0] cv;
    logic [15:0] sv;
    logic [31:0] o_channel_value;
    int num_errors = 0;
    int num_checks = 0;
    int n;
    trc_top #(.N_CH(2)) trc_top_i (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_debug_active(i_debug_active),
        .o_counter_value(o_counter_value), .o_modulus_value(o_modulus_value),
        .o_channel_value(o_channel_value)
    );
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    // ----------------
    // Access tasks
    // ----------------
    // Each access starts just after a rising edge and ends on one, so calls run back to back.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        #1;
        i_wr_en = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(posedge i_ref_clk);
        i_wr_en <= 1'b0;
    endtask
    // Read data is taken at the falling edge; the counter is noted as the design samples it.
    task automatic rd(input logic [3:0] a, output logic [7:0] v, output logic [15:0] c);
        #1;
        i_rd_en = 1'b1;
        i_addr = a;
        c = o_counter_value;
        @(posedge i_ref_clk);
        i_rd_en <= 1'b0;
        @(negedge i_ref_clk);
        v = o_rdata;
        @(posedge i_ref_clk);
    endtask
    task automatic dbg(input logic v);
        #1;
        i_debug_active = v;
        @(posedge i_ref_clk);
    endtask
    // Ends at a falling edge so outputs are settled; the caller returns to the rising edge.
    task automatic settle(input int k);
        repeat (k) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    initial begin
        i_sys_rst = 1'b1;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        i_debug_active = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        repeat (4) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        settle(0);
        chk(o_counter_value | o_modulus_value | o_channel_value[15:0], 16'h0000, "reset");
        @(posedge i_ref_clk);
        rd(4'hb, rv, cv);
        chk(rv, 8'h00, "unmapped read");
        wr(C1_VH, 8'h5a);
        wr(C1_VL, 8'ha5);
        settle(2);
        chk(o_channel_value[31:16], 16'h0000, "capture write");
        @(posedge i_ref_clk);
        // Divide by eight: the first tick must come eight edges after the counter write.
        wr(`TRC_OFS_SC, 8'h0b);
        wr(C0_SC, 8'h10);
        wr(`TRC_OFS_CNTL, 8'h00);
        wr(C0_VH, 8'h12);
        wr(C0_VL, 8'h34);
        for (n = 2; n < 40; n++) begin
            @(negedge i_ref_clk);
            if (o_counter_value !== 16'h0000)
                break;
            chk(o_channel_value[15:0], 16'h0000, "compare early");
            @(posedge i_ref_clk);
        end
        guard(n, 40);
        chk(o_channel_value[15:0], 16'h1234, "compare commit");
        chk(n[15:0], 16'h0008, "prescaler restart");
        @(posedge i_ref_clk);
        wr(`TRC_OFS_MODH, 8'h00);
        wr(`TRC_OFS_MODL, 8'h10);
        for (int m = 0; m < 2; m++) begin
            wr(`TRC_OFS_SC, m ? 8'h28 : 8'h08);
            wr(C0_SC, 8'h20);
            wr(`TRC_OFS_CNTL, 8'h00);
            sv = o_channel_value[15:0];
            wr(C0_VH, 8'h40);
            wr(C0_VL, m[7:0]);
            for (n = 0; n < 40; n++) begin
                @(negedge i_ref_clk);
                if (o_counter_value === 16'h0010)
                    break;
                chk(o_channel_value[15:0], sv, "pwm early");
                @(posedge i_ref_clk);
            end
            guard(n, 40);
            chk(o_channel_value[15:0], {8'h40, m[7:0]}, "pwm commit");
            @(posedge i_ref_clk);
        end
        wr(`TRC_OFS_SC, 8'h08);
        rd(`TRC_OFS_CNTH, rv, sv);
        repeat (3) @(posedge i_ref_clk);
        rd(`TRC_OFS_CNTL, rv, cv);
        chk(rv, sv[7:0], "counter snapshot");
        // A stale latch is left pending, then dropped by a status or counter write in debug.
        for (int k = 0; k < 2; k++) begin
            rd(`TRC_OFS_CNTH, rv, sv);
            repeat (2) @(posedge i_ref_clk);
            dbg(1'b1);
            rd(`TRC_OFS_CNTL, rv, cv);
            chk(rv, cv[7:0], "debug live read");
            wr(k ? `TRC_OFS_CNTH : `TRC_OFS_SC, k ? 8'h00 : 8'h08);
            dbg(1'b0);
            repeat (3) @(posedge i_ref_clk);
            rd(`TRC_OFS_CNTL, rv, cv);
            chk(rv, cv[7:0], "counter latch dropped");
            rd(`TRC_OFS_CNTH, rv, cv);
        end
        wr(`TRC_OFS_SC, 8'h00);
        wr(C0_SC, 8'h10);
        wr(C0_VH, 8'h11);
        wr(C0_VL, 8'h22);
        rd(C0_VH, rv, cv);
        wr(C0_VH, 8'h33);
        wr(C0_VL, 8'h44);
        dbg(1'b1);
        rd(C0_VL, rv, cv);
        chk(rv, 8'h44, "debug value read");
        wr(C0_SC, 8'h10);
        dbg(1'b0);
        rd(C0_VL, rv, cv);
        chk(rv, 8'h44, "value latch dropped");
        wr(C0_VH, 8'h55);
        wr(C0_VL, 8'h66);
        rd(C0_VH, rv, cv);
        chk(rv, 8'h33, "value snapshot");
        dbg(1'b1);
        wr(`TRC_OFS_MODH, 8'h12);
        wr(`TRC_OFS_SC, 8'h00);
        wr(`TRC_OFS_MODL, 8'h34);
        settle(2);
        chk(o_modulus_value, 16'h0010, "modulus pairing dropped");
        @(posedge i_ref_clk);
        wr(`TRC_OFS_MODH, 8'h56);
        settle(2);
        chk(o_modulus_value, 16'h5634, "modulus pair");
        @(posedge i_ref_clk);
        dbg(1'b0);
        final_report();
    end
endmodule
